// ### ctsc_regs.vh
// register map and constants of the seconds clock timer
`ifndef CTSC_REGS_VH
`define CTSC_REGS_VH
`define CTSC_ADDR_CTRL      16'hFF50
`define CTSC_ADDR_TAPS      16'hFF51
`define CTSC_ADDR_SECS      16'hFF52
`define CTSC_BIT_RUN        0
`define CTSC_BIT_RST        1
`define CTSC_RST_CTRL       1'b0
`define CTSC_RST_TAPS       8'h00
`define CTSC_RST_UNITS      4'h0
`define CTSC_RST_TENS       3'h0
`define CTSC_UNITS_MAX      4'h9
`define CTSC_TENS_MAX       3'h5
`define CTSC_SYS_HZ         32'h05F5E100
`define CTSC_TAP0_HZ        32'h00000100
`endif

// ### ctsc_clock_timer.v
// seconds clock timer with divider taps and bcd seconds count
//
// Notes on behaviour
// - run bit starts and halts timer
// - writing one to reset bit clears prescaler and taps, not seconds count
// - eight read-only taps, 128 Hz to 1 Hz
// - units BCD digit in bits 3..0
// - tens BCD digit in bits 6..4
`timescale 1ns/1ps
`include "ctsc_regs.vh"
module ctsc_clock_timer #(
  parameter TICK_DIV = `CTSC_SYS_HZ / `CTSC_TAP0_HZ
) (
  // clock and reset
  input  wire        i_clk_sys,
  input  wire        i_rst,
  // register port
  input  wire [15:0] i_addr,
  input  wire [7:0]  i_wdata,
  input  wire        i_wr,
  input  wire        i_rd,
  output reg  [7:0]  o_rdata,
  // status
  output reg         o_timer_run_control,
  output reg  [7:0]  o_taps
);

  // ----------------------------------------
  // local constants
  // ----------------------------------------
  localparam [31:0] PRE_LAST   = TICK_DIV - 1;
  localparam [31:0] PRE_ZERO   = 32'h00000000;
  localparam [31:0] PRE_STEP   = 32'h00000001;
  localparam [7:0]  TAPS_LAST  = 8'hFF;
  localparam [7:0]  TAPS_STEP  = 8'h01;
  localparam [3:0]  UNITS_ZERO = 4'h0;
  localparam [3:0]  UNITS_STEP = 4'h1;
  localparam [2:0]  TENS_ZERO  = 3'h0;
  localparam [2:0]  TENS_STEP  = 3'h1;

  // ----------------------------------------
  // registers and next values
  // ----------------------------------------
  reg  [31:0] pre_r;
  reg  [31:0] pre_nxt;
  reg         run_r;
  reg         run_nxt;
  reg  [7:0]  taps_r;
  reg  [7:0]  taps_nxt;
  reg  [3:0]  units_r;
  reg  [3:0]  units_nxt;
  reg  [2:0]  tens_r;
  reg  [2:0]  tens_nxt;
  reg  [7:0]  rdata_nxt;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  wire        sel_ctrl;
  wire        sel_taps;
  wire        sel_secs;
  wire        wr_ctrl;
  wire        wr_secs;
  wire        tmr_rst;

  assign sel_ctrl = (i_addr == `CTSC_ADDR_CTRL);
  assign sel_taps = (i_addr == `CTSC_ADDR_TAPS);
  assign sel_secs = (i_addr == `CTSC_ADDR_SECS);
  assign wr_ctrl  = i_wr && sel_ctrl;
  assign wr_secs  = i_wr && sel_secs;
  assign tmr_rst  = wr_ctrl && i_wdata[`CTSC_BIT_RST];

  // ----------------------------------------
  // divider events
  // ----------------------------------------
  wire        pre_end;
  wire        tick;
  wire        sec_tick;
  wire        units_end;
  wire        tens_end;

  assign pre_end   = (pre_r == PRE_LAST);
  assign tick      = run_r && pre_end;
  assign sec_tick  = tick && (taps_r == TAPS_LAST);
  assign units_end = (units_r >= `CTSC_UNITS_MAX);
  assign tens_end  = (tens_r >= `CTSC_TENS_MAX);

  // ----------------------------------------
  // run control
  // ----------------------------------------
  always @* begin
    run_nxt = run_r;
    if (wr_ctrl) begin
      run_nxt = i_wdata[`CTSC_BIT_RUN];
    end
  end

  // ----------------------------------------
  // prescaler
  // ----------------------------------------
  always @* begin
    pre_nxt = pre_r;
    if (tmr_rst) begin
      pre_nxt = PRE_ZERO;
    end else if (run_r) begin
      if (pre_end) begin
        pre_nxt = PRE_ZERO;
      end else begin
        pre_nxt = pre_r + PRE_STEP;
      end
    end
  end

  // ----------------------------------------
  // divider taps
  // ----------------------------------------
  always @* begin
    taps_nxt = taps_r;
    if (tmr_rst) begin
      taps_nxt = `CTSC_RST_TAPS;
    end else if (tick) begin
      taps_nxt = taps_r + TAPS_STEP;
    end
  end

  // ----------------------------------------
  // seconds count
  // ----------------------------------------
  always @* begin
    units_nxt = units_r;
    tens_nxt  = tens_r;
    if (wr_secs) begin
      units_nxt = i_wdata[3:0];
      tens_nxt  = i_wdata[6:4];
    end else if (sec_tick) begin
      if (units_end) begin
        units_nxt = UNITS_ZERO;
        if (tens_end) begin
          tens_nxt = TENS_ZERO;
        end else begin
          tens_nxt = tens_r + TENS_STEP;
        end
      end else begin
        units_nxt = units_r + UNITS_STEP;
      end
    end
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always @* begin
    rdata_nxt = 8'h00;
    if (i_rd) begin
      case (i_addr)
        `CTSC_ADDR_CTRL: begin
          rdata_nxt = {7'h00, run_r};
        end
        `CTSC_ADDR_TAPS: begin
          rdata_nxt = taps_r;
        end
        `CTSC_ADDR_SECS: begin
          rdata_nxt = {1'b0, tens_r, units_r};
        end
        default: begin
          rdata_nxt = 8'h00;
        end
      endcase
    end
  end

  // ----------------------------------------
  // control flops
  // ----------------------------------------
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      run_r <= `CTSC_RST_CTRL;
    end else begin
      run_r <= run_nxt;
    end
  end

  // ----------------------------------------
  // divider flops
  // ----------------------------------------
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      pre_r  <= PRE_ZERO;
      taps_r <= `CTSC_RST_TAPS;
    end else begin
      pre_r  <= pre_nxt;
      taps_r <= taps_nxt;
    end
  end

  // ----------------------------------------
  // seconds flops
  // ----------------------------------------
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      units_r <= `CTSC_RST_UNITS;
      tens_r  <= `CTSC_RST_TENS;
    end else begin
      units_r <= units_nxt;
      tens_r  <= tens_nxt;
    end
  end

  // ----------------------------------------
  // output flops
  // ----------------------------------------
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_rdata             <= 8'h00;
      o_timer_run_control <= 1'b0;
      o_taps              <= 8'h00;
    end else begin
      o_rdata             <= rdata_nxt;
      o_timer_run_control <= run_r;
      o_taps              <= taps_r;
    end
  end

  // sel_taps marks the read-only tap register; writes to it are ignored
  wire        taps_wr_ignored;
  assign taps_wr_ignored = i_wr && sel_taps;

endmodule // ctsc_clock_timer

// ### ctsc_chk.sv
// checker of the seconds clock timer
`timescale 1ns/1ps
module ctsc_chk (input wire i_clk_sys, input wire i_rst, input wire [15:0] i_addr,
  input wire [7:0] i_wdata, input wire i_wr, input wire i_rd, input wire [7:0] o_rdata,
  input wire o_timer_run_control, input wire [7:0] o_taps);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  sequence s_wc; i_wr && i_addr == 16'hFF50; endsequence
  property p_run; s_wc |-> ##2 o_timer_run_control == $past(i_wdata[0], 2); endproperty
  a_run: assert property (p_run) else $error("run bit");
  property p_clr; s_wc ##0 i_wdata[1] |-> ##2 o_taps == 8'h00; endproperty
  a_clr: assert property (p_clr) else $error("tap clear");
  property p_tap; o_taps != $past(o_taps) && o_taps != 8'h00 |->
    o_taps == $past(o_taps) + 8'h01; endproperty
  a_tap: assert property (p_tap) else $error("tap step");
  property p_hlt; !o_timer_run_control [*3] ##0 !$past(i_wr) && !$past(i_wr, 2)
    |-> $stable(o_taps); endproperty
  a_hlt: assert property (p_hlt) else $error("halt");
  property p_sec; i_wr && i_addr == 16'hFF52 && i_wdata == 8'h59 ##[1:2]
    i_rd && i_addr == 16'hFF52 |=> o_rdata == 8'h59; endproperty
  a_sec: assert property (p_sec) else $error("seconds");
  sequence s_rc; i_rd && i_addr == 16'hFF50; endsequence
  property p_ctl; s_rc |=> o_rdata[7:1] == 7'h00; endproperty
  a_ctl: assert property (p_ctl) else $error("control read");
  property p_rdz; !$past(i_rd) |-> o_rdata == 8'h00; endproperty
  a_rdz: assert property (p_rdz) else $error("idle read data");
endmodule // ctsc_chk

// ### ctsc_clock_timer_tb.sv
// testbench of the seconds clock timer
`timescale 1ns/1ps
module ctsc_clock_timer_tb;
  reg c = 0, r = 1, w = 0, d = 0;
  reg [15:0] a = 0;
  reg [7:0] wd = 0;
  wire [7:0] q, t;
  wire o;
  integer err_count = 0, num_checks = 0, n = 0;
  ctsc_clock_timer #(.TICK_DIV(2)) u_ctsc_clock_timer (.i_clk_sys(c), .i_rst(r),
    .i_addr(a), .i_wdata(wd), .i_wr(w), .i_rd(d), .o_rdata(q),
    .o_timer_run_control(o), .o_taps(t));
  initial forever #5 c = ~c;
  task close_out;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge c) if (++n > 3000) begin err_count++; close_out; end
  task chk(input string nm, input [7:0] s, input [7:0] e);
    num_checks++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %0s exp %h got %h", nm, e, s);
    end
  endtask
  task wr(input [15:0] x, input [7:0] v);
    @(posedge c) begin a <= x; wd <= v; w <= 1; end
    @(posedge c) w <= 0;
  endtask
  task rd(input [15:0] x, input [7:0] e);
    @(posedge c) begin a <= x; d <= 1; end
    @(posedge c) d <= 0;
    #1 chk("rdata", q, e);
  endtask
  task t_regs;
    chk("taps", t, 8'h00);
    chk("run", {7'h00, o}, 8'h00);
    rd(16'hFF50, 8'h00);
    rd(16'hFF51, 8'h00);
    rd(16'hFF52, 8'h00);
    rd(16'hFF00, 8'h00);
    wr(16'hFF50, 8'h01);
    repeat (2) @(posedge c);
    #1 chk("run", {7'h00, o}, 8'h01);
    repeat (38) @(posedge c);
    wr(16'hFF50, 8'h02);
    rd(16'hFF51, 8'h00);
    rd(16'hFF50, 8'h00);
    chk("taps", t, 8'h00);
    repeat (20) @(posedge c);
    #1 chk("taps", t, 8'h00);
    $display("register test done");
  endtask
  task t_count;
    wr(16'hFF52, 8'h59);
    rd(16'hFF52, 8'h59);
    wr(16'hFF51, 8'hFF);
    rd(16'hFF51, 8'h00);
    wr(16'hFF50, 8'h01);
    repeat (520) @(posedge c);
    rd(16'hFF52, 8'h00);
    $display("count test done");
  endtask
  task t_carry;
    wr(16'hFF50, 8'h02);
    wr(16'hFF52, 8'h09);
    wr(16'hFF50, 8'h01);
    repeat (520) @(posedge c);
    rd(16'hFF52, 8'h10);
    $display("carry test done");
  endtask
  initial begin
    repeat (12) @(posedge c);
    r <= 0;
    t_regs;
    t_count;
    t_carry;
    close_out;
  end
endmodule // ctsc_clock_timer_tb
bind ctsc_clock_timer ctsc_chk u_ctsc_chk (.*);
